// ### src/mon_cmd.sv
// Overview of operation
// - Command B0h with feature D6h takes 512-byte pages into the chosen log.
// - Log data is stored from the first block of the log onward.
// - Page count zero aborts the log write without data transfer.
// - A read-only log sector rejects the write with the abort bit.
// - Failed write: CRC error bit 7, abort bit 2, status bits 5, 1, 0.
// - Enable D8h turns monitoring on, then saves updated attribute values.
// - Before the first enable, attributes are neither tracked nor saved.
// - The enabled state lives in persistent storage across power cycles.
// - Enable while already enabled leaves attribute values untouched.
// - Disable D9h stops monitoring and autosave, then saves attributes.
// - While disabled, every subcommand except enable aborts, disable too.
// - Old values are kept; refresh only on attribute read or save.
// - Return status DAh saves pre-failure values, then checks thresholds.
// - No threshold exceeded: cylinder low 4Fh, cylinder high C2h.
// - Threshold exceeded: cylinder low F4h, cylinder high 2Ch.
// - Return status shows alignment bit 2, fault, sense and error bits.
// - Logs 00h, 01h, 06h are read-only; 09h and 80h-9Fh writable.
// - Logs 03h and 07h abort, reachable only by extended commands.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module mon_cmd
  import mon_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // AXI4-Lite write channels
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  // AXI4-Lite read channels
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [7:0]  ARADDR,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  // Persistent enable storage
  input  wire logic        NV_ENABLE,
  output logic             NV_STORE,
  output logic             MON_ENABLED,
  // Attribute engine
  output logic             ATTR_SAVE,
  output logic             PREFAIL_SAVE,
  input  wire logic        THRESHOLD_EXCEEDED,
  // Drive condition
  input  wire logic        DEVICE_FAULT,
  input  wire logic        SENSE_AVAILABLE,
  input  wire logic        ALIGNMENT_ERROR,
  input  wire logic        INTERFACE_CRC,
  // Log sector write port
  output logic             LOG_VALID,
  output logic [7:0]       LOG_SECTOR,
  output logic [14:0]      LOG_INDEX,
  output logic [31:0]      LOG_DATA
);

  typedef struct packed {
    logic        aw_held;
    logic [7:0]  awaddr;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  feature;
    logic [7:0]  count;
    logic [23:0] lba;
    logic [7:0]  status;
    logic [7:0]  error;
    logic [7:0]  cyl_lo;
    logic [7:0]  cyl_hi;
    logic        loaded;
    logic        enabled;
    fsm_type     state;
    logic [14:0] words_left;
    logic [14:0] word_index;
    logic [7:0]  sector;
    logic        log_valid;
    logic [31:0] log_data;
    logic [14:0] log_index;
    logic        save;
    logic        prefail;
    logic        nv_store;
  } state_type;

  state_type r;
  state_type next_r;

  // ------------------------------------------------------------
  // Log sector access class
  // ------------------------------------------------------------
  // Only the selective log and the host vendor range accept writes;
  // everything else, including the extended logs, aborts.
  function automatic logic writable(input logic [7:0] s);
    writable = (s == LOG_SELECTIVE) ||
               (s >= LOG_HOST_LO && s <= LOG_HOST_HI);
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic       start;
    logic       abort;
    logic [7:0] busy_bits;
    start = 1'b0;
    abort = 1'b0;
    busy_bits = 8'h00;
    next_r = r;
    next_r.log_valid = 1'b0;
    next_r.save = 1'b0;
    next_r.prefail = 1'b0;
    next_r.nv_store = 1'b0;

    // Stored enable is picked up once, right after reset
    if (!r.loaded) begin
      next_r.loaded = 1'b1;
      next_r.enabled = NV_ENABLE;
    end

    // Write address and data may arrive in either order
    if (AWVALID && !r.aw_held) begin
      next_r.aw_held = 1'b1;
      next_r.awaddr = AWADDR;
    end
    if (WVALID && !r.w_held) begin
      next_r.w_held = 1'b1;
      next_r.wdata = WDATA;
      next_r.wstrb = WSTRB;
    end
    if (r.bvalid && BREADY) begin
      next_r.bvalid = 1'b0;
    end

    if (r.aw_held && r.w_held && !r.bvalid) begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      case (r.awaddr)
        OFS_FEATURE: begin
          if (r.wstrb[0]) begin
            next_r.feature = r.wdata[7:0];
          end
        end
        OFS_COUNT: begin
          if (r.wstrb[0]) begin
            next_r.count = r.wdata[7:0];
          end
        end
        OFS_LBA: begin
          for (int i = 0; i < 3; i++) begin
            if (r.wstrb[i]) begin
              next_r.lba[i*8 +: 8] = r.wdata[i*8 +: 8];
            end
          end
        end
        OFS_COMMAND: begin
          // A command written while one is running is dropped
          start = r.wstrb[0] && r.state == S_IDLE;
        end
        OFS_LOGDATA: begin
          if (r.state == S_DATA) begin
            if (INTERFACE_CRC) begin
              next_r.error[ERR_CRC] = 1'b1;
              next_r.error[ERR_ABORT] = 1'b1;
              next_r.status[ST_ERROR] = 1'b1;
              next_r.state = S_IDLE;
            end else begin
              next_r.log_valid = 1'b1;
              next_r.log_data = r.wdata;
              next_r.log_index = r.word_index;
              next_r.word_index = r.word_index + 15'd1;
              next_r.words_left = r.words_left - 15'd1;
              if (r.words_left == 15'd1) begin
                next_r.state = S_IDLE;
              end
            end
          end
        end
        OFS_STATUS, OFS_ERROR, OFS_CYL, OFS_MONITOR: begin
        end
        default: begin
          next_r.bresp = RESP_DECERR;
        end
      endcase
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    if (start) begin
      next_r.error = 8'h00;
      next_r.status = 8'h00;
      next_r.status[ST_FAULT] = DEVICE_FAULT;
      next_r.status[ST_SENSE] = SENSE_AVAILABLE;
      if (r.wdata[7:0] != CMD_MONITOR || r.lba[23:8] != SIGNATURE) begin
        abort = 1'b1;
      end else if (!r.enabled && r.feature != SUB_ENABLE) begin
        abort = 1'b1;
      end else begin
        case (r.feature)
          SUB_LOGW: begin
            if (r.count == 8'h00) begin
              abort = 1'b1;
            end else if (!writable(r.lba[7:0])) begin
              abort = 1'b1;
            end else begin
              next_r.state = S_DATA;
              next_r.sector = r.lba[7:0];
              next_r.word_index = 15'd0;
              next_r.words_left = {r.count, {WORDS_LOG2{1'b0}}};
            end
          end
          SUB_ENABLE: begin
            // Repeat enable must not touch attribute values
            if (!r.enabled) begin
              next_r.save = 1'b1;
              next_r.nv_store = 1'b1;
            end
            next_r.enabled = 1'b1;
          end
          SUB_DISABLE: begin
            next_r.enabled = 1'b0;
            next_r.save = 1'b1;
            next_r.nv_store = 1'b1;
          end
          SUB_STATUS: begin
            next_r.prefail = 1'b1;
            next_r.state = S_CHECK;
          end
          default: begin
            abort = 1'b1;
          end
        endcase
      end
      if (abort) begin
        next_r.error[ERR_ABORT] = 1'b1;
        next_r.status[ST_ERROR] = 1'b1;
      end
    end

    // Thresholds are compared in the same cycle as the pre-failure save pulse
    if (r.state == S_CHECK) begin
      if (THRESHOLD_EXCEEDED) begin
        next_r.cyl_lo = CYL_LO_FAIL;
        next_r.cyl_hi = CYL_HI_FAIL;
      end else begin
        next_r.cyl_lo = CYL_LO_PASS;
        next_r.cyl_hi = CYL_HI_PASS;
      end
      next_r.status[ST_ALIGN] = ALIGNMENT_ERROR;
      next_r.state = S_IDLE;
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    busy_bits[ST_BUSY] = r.state == S_CHECK;
    busy_bits[ST_DRQ] = r.state == S_DATA;
    if (r.rvalid && RREADY) begin
      next_r.rvalid = 1'b0;
    end
    if (ARVALID && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = 32'h0000_0000;
      case (ARADDR)
        OFS_FEATURE: next_r.rdata[7:0] = r.feature;
        OFS_COUNT:   next_r.rdata[7:0] = r.count;
        OFS_LBA:     next_r.rdata[23:0] = r.lba;
        OFS_COMMAND: next_r.rdata = 32'h0000_0000;
        OFS_STATUS:  next_r.rdata[7:0] = r.status | busy_bits;
        OFS_ERROR:   next_r.rdata[7:0] = r.error;
        OFS_CYL:     next_r.rdata[15:0] = {r.cyl_hi, r.cyl_lo};
        OFS_LOGDATA: next_r.rdata = 32'h0000_0000;
        OFS_MONITOR: next_r.rdata[0] = r.enabled;
        default:     next_r.rresp = RESP_DECERR;
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign AWREADY = !r.aw_held;
  assign WREADY = !r.w_held;
  assign BVALID = r.bvalid;
  assign BRESP = r.bresp;
  assign ARREADY = !r.rvalid;
  assign RVALID = r.rvalid;
  assign RDATA = r.rdata;
  assign RRESP = r.rresp;
  assign NV_STORE = r.nv_store;
  // Tracking stays off until monitoring is enabled
  assign MON_ENABLED = r.enabled;
  assign ATTR_SAVE = r.save;
  assign PREFAIL_SAVE = r.prefail;
  assign LOG_VALID = r.log_valid;
  assign LOG_SECTOR = r.sector;
  assign LOG_INDEX = r.log_index;
  assign LOG_DATA = r.log_data;

endmodule

`default_nettype wire

// ### src/mon_cmd_pkg.sv
package mon_cmd_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_FEATURE = 8'h00;
  localparam logic [7:0] OFS_COUNT   = 8'h04;
  localparam logic [7:0] OFS_LBA     = 8'h08;
  localparam logic [7:0] OFS_COMMAND = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_ERROR   = 8'h14;
  localparam logic [7:0] OFS_CYL     = 8'h18;
  localparam logic [7:0] OFS_LOGDATA = 8'h1c;
  localparam logic [7:0] OFS_MONITOR = 8'h20;

  // ------------------------------------------------------------
  // Command codes and signature
  // ------------------------------------------------------------
  localparam logic [7:0]  CMD_MONITOR = 8'hb0;
  localparam logic [15:0] SIGNATURE   = 16'hc24f;
  localparam logic [7:0]  SUB_LOGW    = 8'hd6;
  localparam logic [7:0]  SUB_ENABLE  = 8'hd8;
  localparam logic [7:0]  SUB_DISABLE = 8'hd9;
  localparam logic [7:0]  SUB_STATUS  = 8'hda;

  // ------------------------------------------------------------
  // Log sectors and verdicts
  // ------------------------------------------------------------
  localparam logic [7:0] LOG_SELECTIVE = 8'h09;
  localparam logic [7:0] LOG_HOST_LO   = 8'h80;
  localparam logic [7:0] LOG_HOST_HI   = 8'h9f;
  localparam logic [7:0] CYL_LO_PASS   = 8'h4f;
  localparam logic [7:0] CYL_HI_PASS   = 8'hc2;
  localparam logic [7:0] CYL_LO_FAIL   = 8'hf4;
  localparam logic [7:0] CYL_HI_FAIL   = 8'h2c;
  localparam int         WORDS_LOG2    = 7;

  // ------------------------------------------------------------
  // Bit positions
  // ------------------------------------------------------------
  localparam int ERR_CRC    = 7;
  localparam int ERR_ABORT  = 2;
  localparam int ST_BUSY    = 7;
  localparam int ST_FAULT   = 5;
  localparam int ST_DRQ     = 3;
  localparam int ST_ALIGN   = 2;
  localparam int ST_SENSE   = 1;
  localparam int ST_ERROR   = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {S_IDLE, S_DATA, S_CHECK} fsm_type;

endpackage

// ### verification/mon_cmd_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------
// Command block checker
// ----------------------------------------------------------
module mon_cmd_assertions
  import mon_cmd_pkg::*;
(
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  // Observed outputs
  input wire logic        BVALID,
  input wire logic        MON_ENABLED,
  input wire logic        NV_STORE,
  input wire logic        ATTR_SAVE,
  input wire logic        PREFAIL_SAVE,
  input wire logic        LOG_VALID,
  input wire logic [7:0]  LOG_SECTOR,
  input wire logic [14:0] LOG_INDEX
);
  logic [14:0] last_idx;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  // Last stored word, so a skipped index shows up
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      last_idx <= 15'h0;
    end else if (LOG_VALID) begin
      last_idx <= LOG_INDEX;
    end
  end

  store_on_change_a: assert property (
    $changed(MON_ENABLED) && !$past(SYS_RST, 2) |-> NV_STORE)
    else $error("enable state changed without a store");
  store_needs_change_a: assert property (
    NV_STORE |-> MON_ENABLED != $past(MON_ENABLED))
    else $error("store without a state change");
  save_with_store_a: assert property (
    ATTR_SAVE == NV_STORE)
    else $error("attribute save and store disagree");
  prefail_enabled_a: assert property (
    PREFAIL_SAVE |-> MON_ENABLED)
    else $error("prefail save while disabled");
  prefail_pulse_a: assert property (
    PREFAIL_SAVE |=> (!PREFAIL_SAVE) [*2])
    else $error("prefail save repeated");
  log_sector_a: assert property (
    LOG_VALID |-> LOG_SECTOR == 8'h09 || LOG_SECTOR inside {[8'h80:8'h9f]})
    else $error("log word stored to a read-only sector");
  log_on_resp_a: assert property (
    LOG_VALID |-> MON_ENABLED && $rose(BVALID))
    else $error("log word stored outside a write response");
  log_order_a: assert property (
    LOG_VALID && LOG_INDEX != 15'h0 |-> LOG_INDEX == last_idx + 15'h1)
    else $error("log word index skipped");
endmodule
`default_nettype wire

// ### verification/nv_attr_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------
// Persistent store and attribute engine
// ----------------------------------------------------------
module nv_attr_model (
  // Clock
  input  wire logic clock,
  // Store request and state from the block
  input  wire logic store,
  input  wire logic enabled,
  // Wear condition chosen by the bench
  input  wire logic worn,
  // Answers to the block
  output logic      nv_enable,
  output logic      exceeded
);
  // No reset: the bit has to outlive every block reset
  initial nv_enable = 1'b0;
  always @(posedge clock) begin
    if (store) nv_enable <= enabled;
  end
  assign exceeded = worn;
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mon_cmd_pkg::*;
  logic        CLOCK, SYS_RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, worn;
  logic        NV_ENABLE, NV_STORE, MON_ENABLED, ATTR_SAVE, PREFAIL_SAVE;
  logic        THRESHOLD_EXCEEDED, INTERFACE_CRC, LOG_VALID;
  logic        DEVICE_FAULT, SENSE_AVAILABLE, ALIGNMENT_ERROR;
  logic [7:0]  AWADDR, ARADDR, LOG_SECTOR, cur_sec;
  logic [31:0] WDATA, RDATA, LOG_DATA, rdat;
  logic [1:0]  BRESP, RRESP, rresp, bresp;
  logic [14:0] LOG_INDEX;
  logic [31:0] exp_log [0:127];
  logic [7:0]  secs [0:7] = '{8'h00, 8'h01, 8'h03, 8'h06,
                              8'h07, 8'h09, 8'h80, 8'h9f};
  int          n_errors, compares, nidx, n_save, seed, n_pre;

  mon_cmd mon_cmd_i (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY),
    .WDATA(WDATA), .WSTRB(4'hf), .BVALID(BVALID), .BREADY(BREADY),
    .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .NV_ENABLE(NV_ENABLE), .NV_STORE(NV_STORE), .MON_ENABLED(MON_ENABLED),
    .ATTR_SAVE(ATTR_SAVE), .PREFAIL_SAVE(PREFAIL_SAVE),
    .THRESHOLD_EXCEEDED(THRESHOLD_EXCEEDED), .DEVICE_FAULT(DEVICE_FAULT),
    .SENSE_AVAILABLE(SENSE_AVAILABLE), .ALIGNMENT_ERROR(ALIGNMENT_ERROR),
    .INTERFACE_CRC(INTERFACE_CRC), .LOG_VALID(LOG_VALID),
    .LOG_SECTOR(LOG_SECTOR), .LOG_INDEX(LOG_INDEX), .LOG_DATA(LOG_DATA));
  nv_attr_model nv_attr_model_i (.clock(CLOCK), .store(NV_STORE),
    .enabled(MON_ENABLED), .worn(worn), .nv_enable(NV_ENABLE),
    .exceeded(THRESHOLD_EXCEEDED));

  // ----------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task print_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    bresp = BRESP;
  endtask

  task rd(input logic [7:0] a);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    rdat  = RDATA;
    rresp = RRESP;
  endtask

  task rst();
    SYS_RST <= 1'b1;
    repeat (12) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    @(posedge CLOCK);
  endtask

  task cmd(input logic [7:0] f, c, input logic [23:0] lba);
    {DEVICE_FAULT, SENSE_AVAILABLE, ALIGNMENT_ERROR} <= 3'($random(seed));
    nidx = 0;
    cur_sec = lba[7:0];
    wr(OFS_FEATURE, {24'h0, f});
    wr(OFS_COUNT, {24'h0, c});
    wr(OFS_LBA, {8'h0, lba});
    wr(OFS_COMMAND, {24'h0, CMD_MONITOR});
  endtask

  // ----------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------
  function logic [31:0] status_exp(input logic e, da);
    return {26'h0, DEVICE_FAULT, 2'b0, da & ALIGNMENT_ERROR,
            SENSE_AVAILABLE, e};
  endfunction

  function logic writable(input logic [7:0] s);
    return s == 8'h09 || (s >= 8'h80 && s <= 8'h9f);
  endfunction

  // Busy is polled first: the verdict lands a cycle after the response
  task ending(input logic [31:0] err, input logic da);
    rdat = 32'h80;
    while (rdat[ST_BUSY]) rd(OFS_STATUS);
    chk("status", rdat & 32'h2f, status_exp(|err, da));
    rd(OFS_ERROR);
    chk("error", rdat & 32'h84, err);
    chk("write response", {30'h0, bresp}, 32'h0);
  endtask

  task page(input int crc);
    for (int i = 0; i < 128; i++) begin
      exp_log[i] = $random(seed);
      INTERFACE_CRC <= (i == crc);
      wr(OFS_LOGDATA, exp_log[i]);
      if (i == crc) break;
    end
    INTERFACE_CRC <= 1'b0;
  endtask

  always #25 CLOCK = ~CLOCK;

  always @(posedge CLOCK) begin
    if (LOG_VALID === 1'b1) begin
      chk("log sector", {24'h0, LOG_SECTOR}, {24'h0, cur_sec});
      chk("log index", {17'h0, LOG_INDEX}, nidx);
      chk("log data", LOG_DATA, exp_log[LOG_INDEX[6:0]]);
      nidx++;
    end
    if (ATTR_SAVE === 1'b1) n_save++;
    if (PREFAIL_SAVE === 1'b1) n_pre++;
  end

  initial begin
    repeat (20000) @(posedge CLOCK);
    n_errors++;
    print_verdict();
  end

  initial begin
    {seed, n_errors, compares, n_save, nidx, n_pre} = {32'd94, 160'h0};
    {CLOCK, SYS_RST, worn, cur_sec} = {2'b01, 9'h0};
    {AWVALID, WVALID, ARVALID, INTERFACE_CRC, BREADY, RREADY} = 6'h3;
    {AWADDR, ARADDR, WDATA} = 48'h0;
    {DEVICE_FAULT, SENSE_AVAILABLE, ALIGNMENT_ERROR} = 3'h0;
    rst();
    rd(OFS_MONITOR);
    chk("monitor", rdat, 32'h0);
    rd(8'h24);
    chk("unmapped", {30'h0, rresp}, 32'h3);
    wr(8'h24, 32'h0);
    chk("unmapped write", {30'h0, bresp}, 32'h3);
    cmd(SUB_STATUS, 8'h1, {SIGNATURE, 8'h0});
    ending(32'h4, 1'b0);
    cmd(SUB_DISABLE, 8'h1, {SIGNATURE, 8'h0});
    ending(32'h4, 1'b0);
    for (int k = 0; k < 2; k++) begin
      cmd(SUB_ENABLE, 8'h1, {SIGNATURE, 8'h0});
      ending(32'h0, 1'b0);
      chk("attribute saves", n_save, 1);
    end
    rd(OFS_MONITOR);
    chk("monitor", rdat, 32'h1);
    // Valid feature and signature, wrong command code
    wr(OFS_COMMAND, 32'h0000_00b1);
    ending(32'h4, 1'b0);
    cmd(8'h55, 8'h1, {SIGNATURE, 8'h0});
    ending(32'h4, 1'b0);
    cmd(SUB_ENABLE, 8'h1, {16'hc24e, 8'h0});
    ending(32'h4, 1'b0);
    cmd(SUB_LOGW, 8'h0, {SIGNATURE, 8'h80});
    ending(32'h4, 1'b0);
    for (int k = 0; k < 8; k++) begin
      cmd(SUB_LOGW, 8'h1, {SIGNATURE, secs[k]});
      if (writable(secs[k])) page(k == 7 ? 5 : -1);
      ending(!writable(secs[k]) ? 32'h4 : k == 7 ? 32'h84 : 32'h0,
             1'b0);
      chk("words", nidx, k == 7 ? 5 : writable(secs[k]) ? 128 : 0);
    end
    for (int t = 0; t < 2; t++) begin
      worn <= t[0];
      cmd(SUB_STATUS, 8'h1, {SIGNATURE, 8'h0});
      ending(32'h0, 1'b1);
      rd(OFS_CYL);
      chk("cylinder", rdat & 32'hffff,
          worn ? 32'h2cf4 : 32'hc24f);
    end
    chk("prefail saves", n_pre, 2);
    chk("attribute saves", n_save, 1);
    rst();
    rd(OFS_MONITOR);
    chk("monitor", rdat, 32'h1);
    cmd(SUB_DISABLE, 8'h1, {SIGNATURE, 8'h0});
    ending(32'h0, 1'b0);
    chk("attribute saves", n_save, 2);
    rst();
    rd(OFS_MONITOR);
    chk("monitor", rdat, 32'h0);
    print_verdict();
  end
endmodule

bind mon_cmd mon_cmd_assertions mon_cmd_assertions_i (.CLOCK(CLOCK),
  .SYS_RST(SYS_RST), .BVALID(BVALID), .MON_ENABLED(MON_ENABLED),
  .NV_STORE(NV_STORE), .ATTR_SAVE(ATTR_SAVE), .PREFAIL_SAVE(PREFAIL_SAVE),
  .LOG_VALID(LOG_VALID), .LOG_SECTOR(LOG_SECTOR), .LOG_INDEX(LOG_INDEX));
`default_nettype wire
